/* core/osd_consts.vh */
/*
 * Constants for the optical stream decoder: timing, stream framing,
 * clock-divider bit positions, codes and the register map.
 * Assumes a 100 MHz ref_clk and the 160 ns stream cell used on the bench.
 */
`ifndef OSD_CONSTS_VH
`define OSD_CONSTS_VH

// ****************************************
// timing
// ****************************************
`define OSD_CLK_NS 10
`define OSD_CELL_NS 160
`define OSD_CELL_CYC (`OSD_CELL_NS / `OSD_CLK_NS)
`define OSD_CELL_LAST (`OSD_CELL_CYC - 1)
`define OSD_CELL_MID (`OSD_CELL_CYC / 2)
`define OSD_FRAME_CELLS 256
`define OSD_TIMEOUT_FRAMES 2
`define OSD_TIMEOUT_CYC (`OSD_TIMEOUT_FRAMES * `OSD_FRAME_CELLS * `OSD_CELL_CYC)
`define OSD_SETTLE_WCLK 12'hf3c
`define OSD_LOCK_FRAMES 2'h2

// ****************************************
// stream framing
// ****************************************
`define OSD_SYNC_ZEROS 4'ha
`define OSD_ZRUN_MAX 4'hf
`define OSD_SEP_POS 3'h4
`define OSD_GRP_LAST 6'h30
`define OSD_NIB_LAST 3'h5

// ****************************************
// output clock divider
// ****************************************
`define OSD_NCO_STEP 17'h0_0200
`define OSD_H_SCLK 0
`define OSD_H_BCLK 2
`define OSD_H_WCLK 8
`define OSD_H_SLOT 7:3
`define OSD_H_SUB 2:0
`define OSD_H_HALF 7:0
`define OSD_LOAD_AT 8'hf9
`define OSD_DATA_SLOTS 5'h18
`define OSD_PAD_SLOTS 5'h08
`define OSD_SLOT_LAST 5'h1f
`define OSD_SAMPLE_MSB 5'h17

// ****************************************
// codes
// ****************************************
`define OSD_MODE_MASTER 2'h0
`define OSD_MODE_SLAVE 2'h1
`define OSD_FMT_RIGHT 2'h0
`define OSD_FMT_LEFT 2'h1
`define OSD_FMT_RESET 2'h2
`define OSD_FMT_GATED 2'h3

// ****************************************
// registers
// ****************************************
`define OSD_REG_CTRL 12'h000
`define OSD_REG_STATUS 12'h004
`define OSD_REG_TIMECODE 12'h008
`define OSD_CTRL_MODE_LSB 0
`define OSD_CTRL_FMT_LSB 2
`define OSD_CTRL_MUTE 4
`define OSD_CTRL_HOLD 5
`define OSD_RST_MODE 2'h0
`define OSD_RST_FMT 2'h1

`endif

/* core/osd_sync3.v */
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes din is asynchronous to clk; dout follows once stages 2 and 3 agree.
 */
`timescale 1ns/1ns
module osd_sync3 (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (rst) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
      dout <= 1'h0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s2; // a change counts only when two stages agree
      end
    end
  end
endmodule

/* core/osd_frame_mem.v */
/*
 * Sample store: eight channel words of 24 bits, one write port,
 * one read port with registered data. Assumes a single clock.
 */
`timescale 1ns/1ns
module osd_frame_mem (
  input wire clk,
  input wire we,
  input wire [2:0] waddr,
  input wire [23:0] wdata,
  input wire [2:0] raddr,
  output reg [23:0] rdata
);
  reg [23:0] mem [0:7];

  // read data is a register, one cycle after the address
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* core/osd_decoder.v */
/*
 * Optical multichannel audio stream decoder: cell recovery, frame decode,
 * word/bit/system clock generation, serial audio and user-bit outputs,
 * error indication and an APB register slave.
 * Assumes ref_clk at 100 MHz, pins asynchronous, APB on ref_clk.
 */
// Decided for this implementation: the register offsets and the APB interface to the registers.
// Function
// - timing settles after 3900 valid word clocks
// - mode 00 master drives, 01 slave
// - master outputs derive from optical stream
// - slave outputs follow external word clock
// - slave word clock must be frequency locked
// - recovered clock unaligned to slave clocks
// - unstable input after lock raises error
// - accept 16 and 20 bit, 24-bit out
// - user bits: timecode, midi, multiplex flag
// - format 10 is a synchronous reset
// - reset clears state, keeps stream recovery
// - reset stops clocks and mutes data
// - error high until stream established
// - locks by itself without any reset
// - first loop recovers stream clock
// - pass-through retimed on recovered clock rise
// - second loop follows selected word clock
// - format 00 right, 01 left, 11 gated
// - bit clock 64x, recovered clock 256x
// - error hold keeps error until released
// - mute input silences data outputs
`timescale 1ns/1ns
`include "osd_consts.vh"
module osd_decoder #(
  parameter [15:0] TIMEOUT_CYC = `OSD_TIMEOUT_CYC
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire optical_stream_in,
  input wire word_clock_in,
  output reg word_clock_out,
  output reg word_clock_oe,
  output reg system_clock_out,
  output reg bit_clock_out,
  output reg recovered_stream_clock,
  output reg stream_pass_through_out,
  output reg out_ch12,
  output reg out_ch34,
  output reg out_ch56,
  output reg out_ch78,
  output reg timecode_bit_out,
  output reg midi_bit_out,
  output reg multiplex_indicator_bit_out,
  output reg reserved_user_bit,
  output reg error_out
);
  // ****************************************
  // control and reset
  // ****************************************
  reg [1:0] mode;
  reg [1:0] fmt;
  reg mute;
  reg hold_sel;
  wire fmt_rst = (fmt == `OSD_FMT_RESET);
  wire core_rst = sys_rst | fmt_rst;
  wire is_master = (mode == `OSD_MODE_MASTER);
  wire opt_s;
  wire wclk_s;

  // one bit of a 32-slot half word
  function slot_bit;
    input [23:0] x;
    input [4:0] s;
    input right;
    reg [4:0] idx;
    begin
      idx = 5'h00;
      slot_bit = 1'h0;
      if (right) begin
        idx = `OSD_SLOT_LAST - s;
        slot_bit = (s < `OSD_PAD_SLOTS) ? x[`OSD_SAMPLE_MSB] : x[idx];
      end else if (s < `OSD_DATA_SLOTS) begin
        idx = `OSD_SAMPLE_MSB - s;
        slot_bit = x[idx];
      end
    end
  endfunction

  osd_sync3 u_sync_opt (
    .clk(ref_clk),
    .rst(sys_rst),
    .din(optical_stream_in),
    .dout(opt_s)
  );

  osd_sync3 u_sync_wclk (
    .clk(ref_clk),
    .rst(sys_rst),
    .din(word_clock_in),
    .dout(wclk_s)
  );

  // ****************************************
  // cell recovery, first loop
  // ****************************************
  reg [4:0] cell_ph;
  reg opt_d;
  reg edge_seen;
  reg bit_stb;
  reg bit_val;
  reg mid_level;
  wire opt_edge = opt_s ^ opt_d;

  // only sys_rst touches this: the stream lock survives a format reset
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cell_ph <= 5'h00;
      opt_d <= 1'h0;
      edge_seen <= 1'h0;
      bit_stb <= 1'h0;
      bit_val <= 1'h0;
      mid_level <= 1'h0;
      recovered_stream_clock <= 1'h0;
      stream_pass_through_out <= 1'h0;
    end else begin
      opt_d <= opt_s;
      if (opt_edge) begin
        cell_ph <= 5'h00;
      end else if (cell_ph == `OSD_CELL_LAST) begin
        cell_ph <= 5'h00;
      end else begin
        cell_ph <= cell_ph + 5'h01;
      end
      bit_stb <= (cell_ph == `OSD_CELL_MID);
      // a transition in the cell is a one; a new edge wins over the clear
      if (cell_ph == `OSD_CELL_MID) begin
        bit_val <= edge_seen | opt_edge;
        edge_seen <= opt_edge;
        mid_level <= opt_s;
      end else if (opt_edge) begin
        edge_seen <= 1'h1;
      end
      recovered_stream_clock <= (cell_ph < `OSD_CELL_MID);
      if (cell_ph == 5'h00) begin
        stream_pass_through_out <= mid_level;
      end
    end
  end

  // ****************************************
  // frame decoder
  // ****************************************
  localparam ST_HUNT = 1'b0;
  localparam ST_DATA = 1'b1;
  reg st;
  reg [3:0] zrun;
  reg [2:0] pos;
  reg [5:0] grp;
  reg [2:0] ch;
  reg [2:0] nib;
  reg [23:0] shf;
  reg [2:0] ubits;
  reg [31:0] tcode;
  reg frame_start;
  reg mem_we;
  reg [2:0] mem_wa;
  reg [23:0] mem_wd;
  reg [1:0] good;
  reg valid;
  reg [15:0] tmo;

  // sync is a run of zeros then a one; every fifth bit must be one
  always @(posedge ref_clk) begin
    if (core_rst) begin
      st <= ST_HUNT;
      zrun <= 4'h0;
      pos <= 3'h0;
      grp <= 6'h00;
      ch <= 3'h0;
      nib <= 3'h0;
      shf <= 24'h00_0000;
      ubits <= 3'h0;
      tcode <= 32'h0000_0000;
      frame_start <= 1'h0;
      mem_we <= 1'h0;
      mem_wa <= 3'h0;
      mem_wd <= 24'h00_0000;
      good <= 2'h0;
      valid <= 1'h0;
      tmo <= 16'h0000;
    end else begin
      frame_start <= 1'h0;
      mem_we <= 1'h0;
      if (tmo == TIMEOUT_CYC) begin
        valid <= 1'h0;
        good <= 2'h0;
        st <= ST_HUNT;
        tmo <= 16'h0000;
      end else begin
        tmo <= tmo + 16'h0001;
      end
      if (bit_stb) begin
        if (bit_val) begin
          zrun <= 4'h0;
        end else if (zrun != `OSD_ZRUN_MAX) begin
          zrun <= zrun + 4'h1;
        end
        case (st)
          ST_HUNT: begin
            if (bit_val && (zrun >= `OSD_SYNC_ZEROS)) begin
              st <= ST_DATA;
              pos <= 3'h0;
              grp <= 6'h00;
              ch <= 3'h0;
              nib <= 3'h0;
              frame_start <= 1'h1;
              tmo <= 16'h0000;
            end
          end
          ST_DATA: begin
            if (pos == `OSD_SEP_POS) begin
              pos <= 3'h0;
              grp <= grp + 6'h01;
              if (!bit_val) begin
                st <= ST_HUNT;
                valid <= 1'h0;
                good <= 2'h0;
              end else begin
                if (grp == 6'h00) begin
                  ubits <= shf[2:0];
                  tcode <= {tcode[30:0], shf[0]};
                end else if (nib == `OSD_NIB_LAST) begin
                  mem_we <= 1'h1;
                  mem_wa <= ch;
                  mem_wd <= shf;
                  ch <= ch + 3'h1;
                  nib <= 3'h0;
                end else begin
                  nib <= nib + 3'h1;
                end
                if (grp == `OSD_GRP_LAST) begin
                  st <= ST_HUNT;
                  if (good == `OSD_LOCK_FRAMES - 2'h1) begin
                    valid <= 1'h1;
                  end else begin
                    good <= good + 2'h1;
                  end
                end
              end
            end else begin
              shf <= {shf[22:0], bit_val};
              pos <= pos + 3'h1;
            end
          end
          default: st <= ST_HUNT;
        endcase
      end
    end
  end

  // ****************************************
  // second loop: divider locked to frame start (master) or word clock (slave)
  // ****************************************
  reg wclk_d;
  reg [15:0] per_cnt;
  reg [15:0] period;
  reg [15:0] acc;
  reg [8:0] h;
  reg h_new;
  reg [11:0] settle;
  wire wclk_rise = wclk_s & ~wclk_d;
  wire ref_edge = is_master ? frame_start : wclk_rise;
  wire [16:0] acc_sum = {1'h0, acc} + `OSD_NCO_STEP;
  wire [16:0] acc_rem = acc_sum - {1'h0, period};
  wire run = (period != 16'h0000);

  // 512 half steps per word clock period; phase snaps to each edge
  always @(posedge ref_clk) begin
    if (core_rst) begin
      wclk_d <= wclk_s; // no false rise when a format reset ends with the pin high
      per_cnt <= 16'h0000;
      period <= 16'h0000;
      acc <= 16'h0000;
      h <= 9'h000;
      h_new <= 1'h0;
      settle <= 12'h000;
    end else begin
      wclk_d <= wclk_s;
      h_new <= 1'h0;
      if (ref_edge) begin
        period <= per_cnt;
        per_cnt <= 16'h0001; // the edge cycle itself is the first of the new period
        acc <= 16'h0000;
        h <= 9'h000;
        h_new <= 1'h1;
        if (!valid) begin
          settle <= 12'h000;
        end else if (settle != `OSD_SETTLE_WCLK) begin
          settle <= settle + 12'h001;
        end
      end else begin
        if (per_cnt != 16'hffff) begin
          per_cnt <= per_cnt + 16'h0001;
        end
        if (run && (acc_sum >= {1'h0, period})) begin
          acc <= acc_rem[15:0];
          h <= h + 9'h001;
          h_new <= 1'h1;
        end else if (run) begin
          acc <= acc_sum[15:0];
        end
      end
    end
  end

  // ****************************************
  // sample fetch for the next half word
  // ****************************************
  reg [23:0] hold [0:3];
  reg [2:0] ld_cnt;
  reg ld_busy;
  reg ld_side;
  reg ld_cap;
  reg [1:0] ld_pair;
  wire [23:0] mem_rd;

  osd_frame_mem u_mem (
    .clk(ref_clk),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr({ld_cnt[1:0], ld_side}),
    .rdata(mem_rd)
  );

  // fetched one slot early so slot 0 of the next half is ready
  always @(posedge ref_clk) begin
    if (core_rst) begin
      ld_cnt <= 3'h0;
      ld_busy <= 1'h0;
      ld_side <= 1'h0;
      ld_cap <= 1'h0;
      ld_pair <= 2'h0;
      hold[0] <= 24'h00_0000;
      hold[1] <= 24'h00_0000;
      hold[2] <= 24'h00_0000;
      hold[3] <= 24'h00_0000;
    end else begin
      if (h_new && (h[`OSD_H_HALF] == `OSD_LOAD_AT)) begin
        ld_busy <= 1'h1;
        ld_cnt <= 3'h0;
        ld_side <= ~h[`OSD_H_WCLK];
      end else if (ld_busy) begin
        ld_cnt <= ld_cnt + 3'h1;
        if (ld_cnt == 3'h3) begin
          ld_busy <= 1'h0;
        end
      end
      ld_cap <= ld_busy;
      ld_pair <= ld_cnt[1:0];
      if (ld_cap) begin
        hold[ld_pair] <= mem_rd;
      end
    end
  end

  // ****************************************
  // clock and data outputs
  // ****************************************
  wire quiet = mute | error_out | ~run;
  wire right = (fmt == `OSD_FMT_RIGHT);
  wire [4:0] slot = h[`OSD_H_SLOT];
  wire slot_edge = h_new && (h[`OSD_H_SUB] == 3'h0);

  // under format reset clocks stop low and data is silent
  always @(posedge ref_clk) begin
    if (core_rst) begin
      system_clock_out <= 1'h0;
      bit_clock_out <= 1'h0;
      word_clock_out <= 1'h0;
      out_ch12 <= 1'h0;
      out_ch34 <= 1'h0;
      out_ch56 <= 1'h0;
      out_ch78 <= 1'h0;
      timecode_bit_out <= 1'h0;
      midi_bit_out <= 1'h0;
      multiplex_indicator_bit_out <= 1'h0;
      reserved_user_bit <= 1'h0;
    end else begin
      system_clock_out <= run & ~h[`OSD_H_SCLK];
      word_clock_out <= run & ~h[`OSD_H_WCLK];
      case (fmt)
        `OSD_FMT_RIGHT: bit_clock_out <= run & h[`OSD_H_BCLK];
        `OSD_FMT_GATED: bit_clock_out <= run & ~h[`OSD_H_BCLK] &
                                         (slot < `OSD_DATA_SLOTS);
        default: bit_clock_out <= run & ~h[`OSD_H_BCLK];
      endcase
      reserved_user_bit <= 1'h0;
      if (quiet) begin
        out_ch12 <= 1'h0;
        out_ch34 <= 1'h0;
        out_ch56 <= 1'h0;
        out_ch78 <= 1'h0;
        timecode_bit_out <= 1'h0;
        midi_bit_out <= 1'h0;
        multiplex_indicator_bit_out <= 1'h0;
      end else begin
        if (slot_edge) begin
          out_ch12 <= slot_bit(hold[0], slot, right);
          out_ch34 <= slot_bit(hold[1], slot, right);
          out_ch56 <= slot_bit(hold[2], slot, right);
          out_ch78 <= slot_bit(hold[3], slot, right);
        end
        if (h_new && (h == 9'h000)) begin
          timecode_bit_out <= ubits[0];
          midi_bit_out <= ubits[1];
          multiplex_indicator_bit_out <= ubits[2];
        end
      end
    end
  end

  // ****************************************
  // error pin and word clock direction
  // ****************************************
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      error_out <= 1'h1;
      word_clock_oe <= 1'h0;
    end else begin
      error_out <= ~valid | (error_out & hold_sel);
      word_clock_oe <= is_master;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire is_ctrl = (paddr == `OSD_REG_CTRL);
  wire is_stat = (paddr == `OSD_REG_STATUS);
  wire is_tc = (paddr == `OSD_REG_TIMECODE);
  wire [31:0] ctrl_word = {26'h000_0000, hold_sel, mute, fmt, mode};
  wire [31:0] stat_word = {period, 12'h000, fmt_rst,
                           (settle == `OSD_SETTLE_WCLK), valid, error_out};

  // no wait state: ready rises in the first access cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0000_0000;
      mode <= `OSD_RST_MODE;
      fmt <= `OSD_RST_FMT;
      mute <= 1'h0;
      hold_sel <= 1'h0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= ~(is_ctrl | is_stat | is_tc);
        if (pwrite) begin
          prdata <= 32'h0000_0000;
        end else if (is_ctrl) begin
          prdata <= ctrl_word;
        end else if (is_stat) begin
          prdata <= stat_word;
        end else if (is_tc) begin
          prdata <= tcode;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
      if (apb_done && pwrite && is_ctrl) begin
        mode <= pwdata[`OSD_CTRL_MODE_LSB +: 2];
        fmt <= pwdata[`OSD_CTRL_FMT_LSB +: 2];
        mute <= pwdata[`OSD_CTRL_MUTE];
        hold_sel <= pwdata[`OSD_CTRL_HOLD];
      end
    end
  end
endmodule

/* tb/osd_properties.sv */
/* Port checker for the optical stream decoder.
   Assumes it is bound to osd_decoder and that control writes arrive over APB. */
`timescale 1ns/1ns
module osd_properties (
  input wire ref_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire word_clock_oe,
  input wire word_clock_out,
  input wire system_clock_out,
  input wire bit_clock_out,
  input wire recovered_stream_clock,
  input wire stream_pass_through_out,
  input wire out_ch12,
  input wire out_ch78,
  input wire timecode_bit_out,
  input wire midi_bit_out,
  input wire reserved_user_bit,
  input wire error_out
);
  // ****
  // control shadow
  // ****
  // the control register is not a port, so track it from completed writes
  logic [5:0] ctrl;
  wire quiet = !out_ch12 && !out_ch78 && !timecode_bit_out && !midi_bit_out;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= 6'h04;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      ctrl <= pwdata[5:0];
    end
  end
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ****
  // properties
  // ****
  a_reserved_user_bit_low: assert property (!reserved_user_bit)
    else $error("reserved user bit driven high");
  a_oe_slave: assert property ((ctrl[1:0] != 2'h0) [*3] |-> !word_clock_oe)
    else $error("word clock driven outside master mode");
  a_error_mutes: assert property (error_out [*2] |-> quiet)
    else $error("data live while error is high");
  a_mute_quiet: assert property (ctrl[4] [*3] |-> quiet)
    else $error("data live while muted");
  a_fmt_reset_stops: assert property ((ctrl[3:2] == 2'h2) [*3] |->
    !bit_clock_out && !system_clock_out && !word_clock_out && error_out)
    else $error("clocks running in format reset");
  a_pass_on_rise: assert property ($changed(stream_pass_through_out) |->
    $rose(recovered_stream_clock))
    else $error("pass-through moved off a recovered clock rise");
  a_error_held: assert property (error_out && ctrl[5] |=> error_out)
    else $error("error dropped while hold is set");
  a_reset_state: assert property ($fell(sys_rst) |-> error_out &&
    !word_clock_out && !bit_clock_out && !system_clock_out && !recovered_stream_clock)
    else $error("outputs not at reset state");
endmodule

bind osd_decoder osd_properties u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .word_clock_oe(word_clock_oe),
  .word_clock_out(word_clock_out), .system_clock_out(system_clock_out),
  .bit_clock_out(bit_clock_out), .recovered_stream_clock(recovered_stream_clock),
  .stream_pass_through_out(stream_pass_through_out), .out_ch12(out_ch12),
  .out_ch78(out_ch78), .timecode_bit_out(timecode_bit_out), .midi_bit_out(midi_bit_out),
  .reserved_user_bit(reserved_user_bit), .error_out(error_out)
);

/* tb/osd_stream_source.sv */
/* Stream source model: NRZI frames of 256 cells of 160 ns.
   Assumes the bench changes its controls only between frames. */
`timescale 1ns/1ns
module osd_stream_source (
  input wire run,
  input wire [23:0] sample,
  input wire [3:0] user,
  input wire bad_sep,
  output logic line
);
  bit q[$];
  int i;
  int c;
  initial line = 1'b0;
  // ****
  // frame sender
  // ****
  // a one is a transition; with run low the line stands still (no light)
  always begin
    wait (run === 1'b1);
    #3;
    while (run === 1'b1) begin
      q = {};
      repeat (10) q.push_back(1'b0);
      q.push_back(1'b1);
      for (i = 3; i >= 0; i--) q.push_back(user[i]);
      q.push_back(1'b1);
      // same word on all eight channels; short sources send zero low nibbles
      for (c = 0; c < 8; c++) begin
        for (i = 23; i >= 0; i--) begin
          q.push_back(sample[i]);
          if (i % 4 == 0) q.push_back(!bad_sep);
        end
      end
      foreach (q[j]) begin
        if (q[j]) line = ~line;
        #160;
      end
    end
  end
endmodule

/* tb/optical_audio_stream_decoder_bench.sv */
/* Bench for the optical stream decoder: APB tasks and ordered scenarios.
   Assumes osd_decoder, the stream source model and the checker bind. */
`timescale 1ns/1ns
module optical_audio_stream_decoder_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic wc_in = 1'b0;
  logic wc_run = 1'b0;
  logic run = 1'b0;
  logic bad_sep = 1'b0;
  logic [23:0] sample = 24'h00_0000;
  logic [3:0] user = 4'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, pe, woe, wout, sclk, bclk, rclk, thru;
  logic c12, c34, c56, c78, tc, midi, mux, u3, err, line;
  int n_errors = 0;
  int cmp_count = 0;
  int bcnt = 0;
  int wcnt = 0;
  time t0;
  // ****
  // clocks
  // ****
  always #5 ref_clk = ~ref_clk;
  // slave word clock locked to the 4096-cycle frame, phase left free
  always @(posedge ref_clk) begin
    wcnt <= (wcnt == 2047) ? 0 : wcnt + 1;
    if (wc_run && wcnt == 2047) begin
      wc_in <= ~wc_in;
    end
  end
  always @(posedge bclk) bcnt++;
  osd_decoder DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .optical_stream_in(line), .word_clock_in(wc_in), .word_clock_out(wout),
    .word_clock_oe(woe), .system_clock_out(sclk), .bit_clock_out(bclk),
    .recovered_stream_clock(rclk), .stream_pass_through_out(thru), .out_ch12(c12),
    .out_ch34(c34), .out_ch56(c56), .out_ch78(c78), .timecode_bit_out(tc),
    .midi_bit_out(midi), .multiplex_indicator_bit_out(mux), .reserved_user_bit(u3),
    .error_out(err)
  );
  osd_stream_source src (.run(run), .sample(sample), .user(user), .bad_sep(bad_sep),
    .line(line));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frames(input int n);
    repeat (n * 4096) @(posedge ref_clk);
  endtask
  // one word: channel 1 bits, user bits, bit clock count and word period
  task automatic word_check(input logic slv, input logic rise, input int n,
    input logic [31:0] ev, input logic [3:0] eu, input int eb);
    int b0;
    if (slv) @(posedge wc_in);
    else @(posedge wout);
    #1;
    t0 = $time;
    b0 = bcnt;
    v = 32'h0000_0000;
    repeat (n) begin
      if (rise) @(posedge bclk);
      else @(negedge bclk);
      v = {v[30:0], c12};
    end
    chk(v, ev);
    chk({28'h0, u3, mux, midi, tc}, {28'h0, eu});
    if (slv) @(posedge wc_in);
    else @(posedge wout);
    #1;
    chk(32'(bcnt - b0), 32'(eb));
    chk(32'($time - t0), 32'h0000_a000);
  endtask
  task automatic fmt_case(input logic [1:0] f, input logic [23:0] s, input logic [3:0] u,
    input logic rise, input int n, input logic [31:0] ev, input int eb);
    apb(1'b1, 12'h000, {28'h0, f, 2'h0});
    sample <= s;
    user <= u;
    frames(2);
    word_check(1'b0, rise, n, ev, {1'b0, u[2:0]}, eb);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    #1150000;
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0007, 32'h0000_0001);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk(32'(pe), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    run <= 1'b1;
    wc_run <= 1'b1;
    frames(3);
    chk(32'(err), 32'h0000_0000);
    chk(32'(woe), 32'h0000_0001);
    fmt_case(2'h1, 24'hab_cde0, 4'ha, 1'b0, 24, 32'h00ab_cde0, 64);
    fmt_case(2'h0, 24'h81_2345, 4'h5, 1'b1, 32, 32'hff81_2345, 64);
    fmt_case(2'h3, 24'h9a_5c00, 4'hd, 1'b0, 24, 32'h009a_5c00, 48);
    apb(1'b1, 12'h000, 32'h0000_0014);
    word_check(1'b0, 1'b0, 24, 32'h0000_0000, 4'h0, 64);
    apb(1'b1, 12'h000, 32'h0000_0024);
    bad_sep <= 1'b1;
    frames(2);
    chk(32'(err), 32'h0000_0001);
    bad_sep <= 1'b0;
    frames(3);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0004);
    repeat (4) @(posedge ref_clk);
    chk(32'(err), 32'h0000_0000);
    // format reset held far beyond the shortest accepted pulse
    apb(1'b1, 12'h000, 32'h0000_0008);
    repeat (12) @(posedge ref_clk);
    chk({28'h0, bclk, sclk, wout, err}, 32'h0000_0001);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0008, 32'h0000_0008);
    @(posedge rclk);
    t0 = $time;
    @(posedge rclk);
    chk(32'($time - t0), 32'h0000_00a0);
    // leave format reset straight into slave mode to keep the run short
    apb(1'b1, 12'h000, 32'h0000_0005);
    frames(3);
    chk(32'(err), 32'h0000_0000);
    chk(32'(woe), 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({16'h0, rd[31:16]}, 32'h0000_1000);
    word_check(1'b1, 1'b0, 24, {8'h00, sample}, {1'b0, user[2:0]}, 64);
    stop_test;
  end
endmodule
